// ---- core/idac_host.sv ----
// Host end of the two-wire link: one word write or read per command.
// Assumes a single target that answers within a quarter bit period.
`default_nettype none
module idac_host
  import idac_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  idac_if.host bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_read_i,
  input wire logic cmd_hs_i,
  input wire logic [6:0] cmd_addr_i,
  input wire logic [15:0] cmd_word_i,
  output logic done_o,
  output logic ack_ok_o,
  output logic [15:0] rd_word_o
);
  // =====================================================
  // State
  typedef struct packed {
    idac_mstate_e st; // Current symbol or byte.
    logic [1:0] q; // Quarter of the bit period.
    logic [5:0] tcnt; // Cycles into the quarter.
    logic [3:0] bitcnt; // Bit of the byte, 8 is acknowledge.
    logic [7:0] tx; // Byte being sent.
    logic [8:0] rx; // Byte and its acknowledge, as received.
    logic hs; // Fast clock in use.
    logic want_hs; // Command asked for high speed.
    logic rd; // Command is a read.
    logic [6:0] addr;
    logic [15:0] word;
    logic scl_oe; // Pull clock low.
    logic sda_oe; // Pull data low.
    logic ack_ok; // Every target acknowledge so far was low.
    logic [15:0] rd_word;
    logic done;
  } idac_host_s;
  idac_host_s r_reg;
  idac_host_s r_next;
  logic sda_sync; // Synchronised data line.
  idac_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .d_i(bus.sda),
    .q_o(sda_sync)
  );
  // =====================================================
  // Sequencer and pin drive
  always_comb begin
    logic tick;
    logic val;
    logic bytes;
    val = 1'b1;
    tick = (r_reg.tcnt == 6'((r_reg.hs ? HS_QTR : SF_QTR) - 6'h1));
    r_next = r_reg;
    r_next.done = 1'b0;
    bytes = (r_reg.st == M_MCODE) || (r_reg.st == M_ADDR) ||
            (r_reg.st == M_B0) || (r_reg.st == M_B1);
    if (r_reg.st == M_IDLE) begin
      r_next.tcnt = 6'h0;
      r_next.q = 2'h0;
      if (cmd_valid_i) begin
        r_next.st = M_START; // [R2]
        r_next.want_hs = cmd_hs_i;
        r_next.rd = cmd_read_i;
        r_next.addr = cmd_addr_i;
        r_next.word = cmd_word_i;
        r_next.ack_ok = 1'b1;
        r_next.bitcnt = 4'h0;
      end
    end else if (tick) begin
      r_next.tcnt = 6'h0;
      r_next.q = 2'(r_reg.q + 2'h1);
      // Sample the line once it has been high a whole quarter.
      if (bytes && r_reg.q == 2'h2) begin
        r_next.rx = {r_reg.rx[7:0], sda_sync};
      end
      if (r_reg.q == 2'h3) begin
        if (bytes && r_reg.bitcnt != 4'h8) begin
          r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
          r_next.tx = {r_reg.tx[6:0], 1'b1};
        end else begin
          r_next.bitcnt = 4'h0;
          case (r_reg.st)
            M_START: begin
              if (r_reg.want_hs) begin
                r_next.st = M_MCODE; // [R14]
                r_next.tx = {MCODE_PFX, MCODE_LOW};
              end else begin
                r_next.st = M_ADDR; // [R5] [R7]
                r_next.tx = {r_reg.addr, r_reg.rd};
              end
            end
            M_MCODE: begin
              r_next.hs = 1'b1; // [R14]
              r_next.st = M_RSTART;
            end
            M_RSTART: begin
              r_next.st = M_ADDR; // [R3]
              r_next.tx = {r_reg.addr, r_reg.rd};
            end
            M_ADDR: begin
              r_next.ack_ok = ~r_reg.rx[0];
              r_next.st = r_reg.rx[0] ? M_STOP : M_B0;
              r_next.tx = r_reg.rd ? 8'hff : r_reg.word[15:8];
            end
            M_B0: begin
              if (r_reg.rd) begin
                r_next.rd_word[15:8] = r_reg.rx[8:1];
              end else begin
                r_next.ack_ok = ~r_reg.rx[0];
              end
              r_next.st = (!r_reg.rd && r_reg.rx[0]) ? M_STOP : M_B1;
              r_next.tx = r_reg.rd ? 8'hff : r_reg.word[7:0];
            end
            M_B1: begin
              if (r_reg.rd) begin
                r_next.rd_word[7:0] = r_reg.rx[8:1];
              end else begin
                r_next.ack_ok = ~r_reg.rx[0];
              end
              r_next.st = M_STOP; // [R13]
            end
            default: begin
              r_next.hs = 1'b0; // [R15]
              r_next.done = 1'b1;
              r_next.st = M_IDLE;
            end
          endcase
        end
      end
      // Drive for the quarter now beginning; clock falls first so
      // that only start and stop change data while it is high.
      if (r_next.bitcnt != 4'h8) begin
        val = r_next.tx[7];
      end else if (r_next.rd && r_next.st == M_B0) begin
        val = 1'b0; // [R12]
      end
      case (r_next.q)
        2'h0: begin
          r_next.scl_oe = (r_next.st != M_IDLE);
        end
        2'h1: begin
          if (r_next.st == M_START || r_next.st == M_RSTART) begin
            r_next.sda_oe = 1'b0;
          end else if (r_next.st == M_STOP) begin
            r_next.sda_oe = 1'b1;
          end else begin
            r_next.sda_oe = ~val; // [R6]
          end
        end
        2'h2: begin
          r_next.scl_oe = 1'b0;
        end
        default: begin
          if (r_next.st == M_START || r_next.st == M_RSTART) begin
            r_next.sda_oe = 1'b1; // [R2]
          end else if (r_next.st == M_STOP) begin
            r_next.sda_oe = 1'b0; // [R4]
          end
        end
      endcase
    end else begin
      r_next.tcnt = 6'(r_reg.tcnt + 6'h1);
    end
  end
  // =====================================================
  // State register.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_reg <= '{st: M_IDLE, q: 2'h0, tcnt: 6'h0, bitcnt: 4'h0,
                 tx: 8'h00, rx: 9'h000, hs: 1'b0, want_hs: 1'b0,
                 rd: 1'b0, addr: 7'h00, word: 16'h0000,
                 scl_oe: 1'b0, sda_oe: 1'b0, ack_ok: 1'b0,
                 rd_word: 16'h0000, done: 1'b0};
    end else if (clk_en_i) begin
      r_reg <= r_next;
    end
  end
  assign bus.m_scl_out = 1'b0;
  assign bus.m_scl_oe = r_reg.scl_oe;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = r_reg.sda_oe;
  assign cmd_ready_o = (r_reg.st == M_IDLE);
  assign done_o = r_reg.done;
  assign ack_ok_o = r_reg.ack_ok;
  assign rd_word_o = r_reg.rd_word;
endmodule : idac_host
`default_nettype wire

// ---- core/idac_if.sv ----
// Open-drain two-wire bus joining the host and the target.
// Assumes pull-ups: an undriven line reads high.
`default_nettype none
interface idac_if;
  // =====================================================
  // Per-end drive signals
  logic m_scl_out; // Host clock drive level.
  logic m_scl_oe; // Host drives clock.
  logic m_sda_out; // Host data drive level.
  logic m_sda_oe; // Host drives data.
  logic t_sda_out; // Target data drive level.
  logic t_sda_oe; // Target drives data.
  logic scl; // Resolved clock line.
  logic sda; // Resolved data line.
  // Wired-and of every driver over the pull-up.
  assign scl = m_scl_oe ? m_scl_out : 1'b1;
  assign sda = (m_sda_oe ? m_sda_out : 1'b1) &
               (t_sda_oe ? t_sda_out : 1'b1);
  modport host (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe,
                input scl, sda);
  modport target (output t_sda_out, t_sda_oe, input scl, sda);
endinterface : idac_if
`default_nettype wire

// ---- core/idac_pkg.sv ----
// Shared constants, enums and the address decode for the two-wire
// converter link.
// Assumes a 20 MHz system clock on both ends.
`default_nettype none
package idac_pkg;
  // =====================================================
  // Timing
  localparam int CLK_NS = 50; // System clock period.
  localparam int SF_SCL_NS = 2500; // Standard-fast bit period.
  localparam int HS_SCL_NS = 1000; // High-speed bit period.
  localparam int TSP_SF_NS = 50; // Spike width rejected, slow.
  localparam int TSP_HS_NS = 10; // Spike width rejected, fast.
  // Quarter bit periods, rounded down, never below one cycle.
  localparam int SF_Q = SF_SCL_NS / (4 * CLK_NS);
  localparam int HS_Q = HS_SCL_NS / (4 * CLK_NS);
  localparam logic [5:0] SF_QTR = 6'((SF_Q > 0) ? SF_Q : 1);
  localparam logic [5:0] HS_QTR = 6'((HS_Q > 0) ? HS_Q : 1);
  // A new level must persist one cycle past the spike width.
  localparam logic [1:0] FLT_SF = 2'((TSP_SF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] FLT_HS = 2'((TSP_HS_NS + CLK_NS - 1) / CLK_NS);
  // =====================================================
  // Protocol codes
  localparam logic [4:0] MCODE_PFX = 5'h01; // Top bits of 00001XXX.
  localparam logic [2:0] MCODE_LOW = 3'h0; // Low bits the host sends.
  localparam logic [6:0] BCAST_ADDR = 7'h48; // 1001000.
  // Three-level select codes.
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // Address bases by select input b; a adds 0, 1 or 2.
  localparam logic [6:0] BASE_B_FLOAT = 7'h0c;
  localparam logic [6:0] BASE_B_LOW = 7'h08;
  localparam logic [6:0] BASE_B_HIGH = 7'h4c;
  // =====================================================
  // Converter word layout
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam int MODE_LSB = 12; // Power mode sits at 13:12.
  localparam int DATA_MSB = 11; // Straight binary at 11:0.
  localparam logic [1:0] TOP_ZERO = 2'h0; // Bits 15:14.
  // =====================================================
  // State machines
  typedef enum logic [2:0] {
    T_IDLE, T_ADDR, T_ADDR_ACK, T_WR, T_WR_ACK, T_RD, T_RD_ACK, T_SKIP
  } idac_tstate_e;
  typedef enum logic [2:0] {
    M_IDLE, M_START, M_MCODE, M_RSTART, M_ADDR, M_B0, M_B1, M_STOP
  } idac_mstate_e;
  // Address from the two select levels.
  function automatic logic [6:0] idac_addr(input logic [1:0] a,
                                           input logic [1:0] b);
    logic [6:0] base;
    logic [6:0] off;
    base = (b == LVL_LOW) ? BASE_B_LOW :
           (b == LVL_HIGH) ? BASE_B_HIGH : BASE_B_FLOAT;
    off = (a == LVL_LOW) ? 7'h01 : (a == LVL_HIGH) ? 7'h02 : 7'h00;
    return 7'(base + off);
  endfunction : idac_addr
endpackage : idac_pkg
`default_nettype wire

// ---- core/idac_sync.sv ----
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes each bit is independent; no bus coherence is kept.
`default_nettype none
module idac_sync
  import idac_pkg::*;
#(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // =====================================================
  // State
  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by the second.
    logic [W-1:0] stab; // Second stage, safe to use.
  } idac_sync_s;
  idac_sync_s s_reg;
  idac_sync_s s_next;
  // Shift the pins one stage per cycle.
  always_comb begin
    s_next.meta = d_i;
    s_next.stab = s_reg.meta;
  end
  // Register; a low enable freezes both stages.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end
  assign q_o = s_reg.stab;
endmodule : idac_sync
`default_nettype wire

// ---- core/idac_target.sv ----
// Target end of the two-wire link: the converter register slave.
// Assumes the host keeps each clock phase several system cycles long.
// Operation
// (R1) Acknowledge matching address, release line otherwise.
// (R2) Host opens with data falling, clock high.
// (R3) Repeated start keeps current speed mode.
// (R4) Data rising, clock high is stop.
// (R5) Eight address bits, MSB first, before acknowledge.
// (R6) Host releases data for address acknowledge.
// (R7) Direction bit zero writes, one reads.
// (R8) Acknowledge data bytes; upper byte first.
// (R9) Lower byte acknowledged loads whole word.
// (R10) Further byte pairs keep loading words.
// (R11) Read sends upper byte, then lower.
// (R12) Host acknowledges to request another byte.
// (R13) Host ends read with not-acknowledge, stop.
// (R14) Master code 00001XXX is not acknowledged.
// (R15) High speed lasts until stop.
// (R16) Repeated start in high speed stays fast.
// (R17) Address from two three-level select inputs.
// (R18) Broadcast address writes are also accepted.
// (R19) Lock address on first own match.
// (R20) Top bits zero, mode bits, twelve data.
// (R21) Output changes at lower byte acknowledge.
// (R22) Register is zero from reset on.
// (R23) Synchronise and filter; only pull low.
// (R24) Reads return the word last written.
`default_nettype none
module idac_target
  import idac_pkg::*;
#(
  parameter logic DUAL_SELECT = 1'b1 // Zero: input b reads floating.
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  idac_if.target bus,
  input wire logic [1:0] addr_select_in_a_i,
  input wire logic [1:0] addr_select_in_b_i,
  output logic [15:0] dac_word_o,
  output logic [1:0] power_mode_o,
  output logic [11:0] dac_data_o,
  output logic update_o,
  output logic hs_mode_o,
  output logic addr_locked_o
);
  // =====================================================
  // State
  typedef struct packed {
    logic [1:0] flt; // Filtered {clock, data}.
    logic [1:0][1:0] fcnt; // Cycles a new level has persisted.
    idac_tstate_e st; // Byte-level state.
    logic [3:0] bitcnt; // Bits seen in this byte.
    logic [7:0] shreg; // Shift register, both directions.
    logic rw; // Direction of the current access.
    logic hs; // High-speed mode in effect.
    logic lo_byte; // Current data byte is the lower one.
    logic mack; // Host acknowledged the last read byte.
    logic [7:0] upper; // Upper byte held until the lower arrives.
    logic [15:0] dac; // Converter register.
    logic locked; // Address frozen.
    logic [6:0] own; // Frozen address.
    logic sda_oe; // Pull data low.
    logic update; // Register loaded this cycle.
  } idac_tgt_s;
  idac_tgt_s r_reg;
  idac_tgt_s r_next;
  logic [1:0] line_sync; // Synchronised {clock, data}.
  logic [3:0] sel_sync; // Synchronised {b, a} select levels.
  // =====================================================
  // Pin synchronisers
  idac_sync #(.W(2), .RST_VAL(2'h3)) u_line_sync ( // [R23]
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .d_i({bus.scl, bus.sda}),
    .q_o(line_sync)
  );
  idac_sync #(.W(4), .RST_VAL({LVL_FLOAT, LVL_FLOAT})) u_sel_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i),
    .d_i({addr_select_in_b_i, addr_select_in_a_i}),
    .q_o(sel_sync)
  );
  // =====================================================
  // Next-state logic
  always_comb begin
    logic [1:0] flen;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [6:0] live;
    logic [6:0] cur;
    logic [7:0] nb;
    flen = r_reg.hs ? FLT_HS : FLT_SF;
    r_next = r_reg;
    r_next.update = 1'b0;
    // Spike filter: take a level only once it has persisted.
    for (int i = 0; i < 2; i++) begin
      if (line_sync[i] != r_reg.flt[i]) begin
        if (r_reg.fcnt[i] >= flen) begin
          r_next.flt[i] = line_sync[i]; // [R23]
          r_next.fcnt[i] = 2'h0;
        end else begin
          r_next.fcnt[i] = 2'(r_reg.fcnt[i] + 2'h1);
        end
      end else begin
        r_next.fcnt[i] = 2'h0;
      end
    end
    scl_rise = ~r_reg.flt[1] & r_next.flt[1];
    scl_fall = r_reg.flt[1] & ~r_next.flt[1];
    start = r_reg.flt[1] & r_next.flt[1] & r_reg.flt[0] & ~r_next.flt[0];
    stop = r_reg.flt[1] & r_next.flt[1] & ~r_reg.flt[0] & r_next.flt[0];
    // Live decode until the first own match freezes it.
    live = idac_addr(sel_sync[1:0],
                     DUAL_SELECT ? sel_sync[3:2] : LVL_FLOAT); // [R17]
    cur = r_reg.locked ? r_reg.own : live; // [R19]
    nb = 8'h00;
    if (stop) begin
      // Stop ends any transfer and drops back to slow speed.
      r_next.st = T_IDLE; // [R4]
      r_next.hs = 1'b0; // [R15]
      r_next.sda_oe = 1'b0;
    end else if (start) begin
      // Start and repeated start alike; speed mode is kept.
      r_next.st = T_ADDR; // [R3] [R16]
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (r_reg.st)
        T_ADDR, T_WR: begin
          // Sample data MSB first while the clock is high.
          r_next.shreg = {r_reg.shreg[6:0], r_reg.flt[0]}; // [R5]
          r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
        end
        T_RD: begin
          r_next.bitcnt = 4'(r_reg.bitcnt + 4'h1);
        end
        T_WR_ACK: begin
          // The word lands on the rising clock of the lower ack.
          if (r_reg.lo_byte) begin
            r_next.dac = {TOP_ZERO, r_reg.upper[5:0],
                          r_reg.shreg}; // [R9] [R20] [R21]
            r_next.update = 1'b1; // [R10]
          end
        end
        T_RD_ACK: begin
          r_next.mack = ~r_reg.flt[0]; // [R12]
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r_reg.st)
        T_ADDR: begin
          if (r_reg.bitcnt == 4'h8) begin
            if (r_reg.shreg[7:3] == MCODE_PFX) begin
              // Master code: stay released and go fast.
              r_next.hs = 1'b1; // [R14]
              r_next.st = T_SKIP;
            end else if (r_reg.shreg[7:1] == cur) begin
              r_next.sda_oe = 1'b1; // [R1]
              r_next.rw = r_reg.shreg[0]; // [R7]
              r_next.st = T_ADDR_ACK;
              r_next.locked = 1'b1; // [R19]
              r_next.own = cur;
            end else if (r_reg.shreg[7:1] == BCAST_ADDR &&
                         !r_reg.shreg[0]) begin
              // Broadcast is write only; reads would collide.
              r_next.sda_oe = 1'b1; // [R18]
              r_next.rw = 1'b0;
              r_next.st = T_ADDR_ACK;
            end else begin
              r_next.st = T_SKIP; // [R1]
            end
          end
        end
        T_ADDR_ACK: begin
          r_next.lo_byte = 1'b0;
          r_next.bitcnt = 4'h0;
          if (r_reg.rw) begin
            // Present the upper byte at once.
            r_next.shreg = r_reg.dac[15:8]; // [R11] [R24]
            r_next.sda_oe = ~r_reg.dac[15]; // [R23]
            r_next.st = T_RD;
          end else begin
            r_next.sda_oe = 1'b0;
            r_next.st = T_WR;
          end
        end
        T_WR: begin
          if (r_reg.bitcnt == 4'h8) begin
            r_next.sda_oe = 1'b1; // [R8]
            r_next.st = T_WR_ACK;
            if (!r_reg.lo_byte) begin
              r_next.upper = r_reg.shreg; // [R8]
            end
          end
        end
        T_WR_ACK: begin
          r_next.sda_oe = 1'b0;
          r_next.lo_byte = ~r_reg.lo_byte; // [R10]
          r_next.bitcnt = 4'h0;
          r_next.st = T_WR;
        end
        T_RD: begin
          if (r_reg.bitcnt == 4'h8) begin
            r_next.sda_oe = 1'b0;
            r_next.st = T_RD_ACK;
          end else begin
            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.shreg[6]; // [R11]
          end
        end
        T_RD_ACK: begin
          if (r_reg.mack) begin
            // Alternate bytes; a long read wraps to the upper one.
            nb = r_reg.lo_byte ? r_reg.dac[15:8] : r_reg.dac[7:0];
            r_next.lo_byte = ~r_reg.lo_byte; // [R11]
            r_next.shreg = nb;
            r_next.sda_oe = ~nb[7];
            r_next.bitcnt = 4'h0;
            r_next.st = T_RD;
          end else begin
            r_next.st = T_SKIP; // [R13]
          end
        end
        default: begin
        end
      endcase
    end
  end
  // =====================================================
  // State register; reset clears the converter word.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r_reg <= '{flt: 2'h3, fcnt: '0, st: T_IDLE, bitcnt: 4'h0,
                 shreg: 8'h00, rw: 1'b0, hs: 1'b0, lo_byte: 1'b0,
                 mack: 1'b0, upper: 8'h00, dac: WORD_RST, // [R22]
                 locked: 1'b0, own: 7'h00, sda_oe: 1'b0,
                 update: 1'b0};
    end else if (clk_en_i) begin
      r_reg <= r_next;
    end
  end
  // =====================================================
  // Outputs; the data line is only ever pulled low.
  assign bus.t_sda_out = 1'b0; // [R23]
  assign bus.t_sda_oe = r_reg.sda_oe;
  assign dac_word_o = r_reg.dac;
  assign power_mode_o = r_reg.dac[MODE_LSB+1:MODE_LSB];
  assign dac_data_o = r_reg.dac[DATA_MSB:0];
  assign update_o = r_reg.update;
  assign hs_mode_o = r_reg.hs;
  assign addr_locked_o = r_reg.locked;
endmodule : idac_target
`default_nettype wire

// ---- tb/idac_assertions.sv ----
// Checker on the two-wire bus between host and target ends.
// Assumes pull-ups: a released line reads high.
`default_nettype none
module idac_assertions
  import idac_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic t_sda_out,
  input wire logic t_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================
  // Frame tracking
  logic [1:0] lq; // Clock and data one cycle back.
  logic [3:0] bits; // Clock rises since start, wraps after nine.
  logic [7:0] sh; // First byte, shifted in MSB first.
  logic first, ackd, rd, idle;
  wire start_w = scl && lq[1] && lq[0] && !sda;
  wire stop_w = scl && lq[1] && !lq[0] && sda;
  wire rise_w = scl && !lq[1];
  wire slot_w = rise_w && (bits == 4'h8); // Acknowledge is sampled.
  // Rises before a stop also count; the next start clears them.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lq <= 2'h3;
      bits <= 4'h0;
      sh <= 8'h00;
      first <= 1'b0;
      ackd <= 1'b0;
      rd <= 1'b0;
      idle <= 1'b1;
    end else begin
      lq <= {scl, sda};
      if (start_w) begin
        bits <= 4'h0;
        first <= 1'b1;
        idle <= 1'b0;
      end else if (stop_w) begin
        idle <= 1'b1;
      end else if (rise_w) begin
        bits <= slot_w ? 4'h0 : bits + 4'h1;
        if (!slot_w && first) sh <= {sh[6:0], sda};
        if (slot_w && first) begin
          first <= 1'b0;
          ackd <= !sda;
          rd <= sh[0];
        end
      end
    end
  end
  // ==========================================
  // Properties
  low_only_a: assert property (
    !((t_sda_oe && t_sda_out) || (m_sda_oe && m_sda_out)))
    else $error("A data line was driven high.");
  hold_high_a: assert property (scl && lq[1] |-> $stable(t_sda_oe))
    else $error("Target changed data while clock was high.");
  idle_quiet_a: assert property (idle |-> !t_sda_oe)
    else $error("Target drove data on an idle bus.");
  addr_quiet_a: assert property (first && bits < 4'h8 |-> !t_sda_oe)
    else $error("Target drove data during address bits.");
  addr_release_a: assert property (slot_w && first |-> !m_sda_oe)
    else $error("Host held data in the address slot.");
  mcode_nack_a: assert property (
    slot_w && first && sh[7:3] == MCODE_PFX |-> sda)
    else $error("Master code was acknowledged.");
  bcast_ack_a: assert property (
    slot_w && first && sh == {BCAST_ADDR, 1'b0} |-> !sda)
    else $error("Broadcast write was not acknowledged.");
  byte_ack_a: assert property (
    slot_w && !first && ackd && !rd |-> !sda && !m_sda_oe)
    else $error("Write byte was not acknowledged.");
  cover property (slot_w && first && !sda && rd);
  cover property (slot_w && first && sh[7:3] == MCODE_PFX);
  cover property (slot_w && !first && ackd && !rd);
endmodule : idac_assertions
`default_nettype wire

// ---- tb/test_i2c_dac_register_slave.sv ----
// Bench: host and target ends joined, driven by word commands.
// Assumes target select low/float gives its own address 0001101.
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_i2c_dac_register_slave
  import idac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_hs = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [15:0] cmd_word = 16'h0000;
  logic [1:0] sel_a = LVL_LOW;
  logic [1:0] sel_b = LVL_FLOAT;
  logic cmd_ready, done, ack_ok, update, hs, locked;
  logic hs_seen = 1'b0;
  logic [15:0] rd_word, dac_word;
  logic [1:0] pmode;
  logic [11:0] ddata;
  int err_count = 0;
  int comparisons = 0;
  int upd_count = 0;
  int cycles = 0;
  idac_if link_bus ();
  idac_host u_idac_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .bus(link_bus), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_hs_i(cmd_hs),
    .cmd_addr_i(cmd_addr), .cmd_word_i(cmd_word), .done_o(done),
    .ack_ok_o(ack_ok), .rd_word_o(rd_word));
  // The target runs on the link clock, unrelated to the host clock.
  idac_target u_idac_target (.clock_i(link_clk), .sys_rst_i(sys_rst_i),
    .clk_en_i(1'b1), .bus(link_bus), .addr_select_in_a_i(sel_a),
    .addr_select_in_b_i(sel_b), .dac_word_o(dac_word),
    .power_mode_o(pmode), .dac_data_o(ddata), .update_o(update),
    .hs_mode_o(hs), .addr_locked_o(locked));
  idac_assertions u_idac_assertions (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .m_scl_out(link_bus.m_scl_out),
    .m_scl_oe(link_bus.m_scl_oe), .m_sda_out(link_bus.m_sda_out),
    .m_sda_oe(link_bus.m_sda_oe), .t_sda_out(link_bus.t_sda_out),
    .t_sda_oe(link_bus.t_sda_oe), .scl(link_bus.scl), .sda(link_bus.sda));
  initial forever #25 clock_i = ~clock_i;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // Word loads and fast mode are seen in the target's own domain.
  always @(posedge link_clk) begin
    if (update === 1'b1) upd_count <= upd_count + 1;
    if (hs === 1'b1) hs_seen <= 1'b1;
  end
  // A hung frame ends the run as a mismatch.
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // One whole command; the request is held until ready is seen.
  task automatic xfer(input logic r, input logic h, input logic [6:0] a,
                      input logic [15:0] w, input logic ok);
    @(posedge clock_i);
    {cmd_read, cmd_hs, cmd_addr, cmd_word, cmd_valid} <= {r, h, a, w, 1'b1};
    @(negedge clock_i);
    while (cmd_ready !== 1'b1) @(negedge clock_i);
    @(posedge clock_i);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) @(negedge clock_i);
    `CHK("ack_ok", ok, ack_ok)
    if (r && ok) `CHK("rd_word", w, rd_word)
  endtask : xfer
  initial begin
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    `CHK("dac_word", 16'h0000, dac_word)
    xfer(0, 0, 7'h0e, 16'h0fff, 0);
    `CHK("dac_word", 16'h0000, dac_word)
    `CHK("locked", 1'b0, locked)
    xfer(0, 0, 7'h0d, 16'h3abc, 1);
    `CHK("pmode", 2'h3, pmode)
    `CHK("ddata", 12'habc, ddata)
    `CHK("locked", 1'b1, locked)
    @(posedge clock_i);
    sel_a <= LVL_HIGH;
    sel_b <= LVL_HIGH;
    xfer(0, 0, 7'h4e, 16'h0fff, 0);
    xfer(0, 0, 7'h0d, 16'hc123, 1);
    `CHK("dac_word", 16'h0123, dac_word)
    xfer(1, 0, 7'h0d, 16'h0123, 1);
    `CHK("hs_seen", 1'b0, hs_seen)
    xfer(0, 1, 7'h0d, 16'h1555, 1);
    `CHK("hs_seen", 1'b1, hs_seen)
    `CHK("hs", 1'b0, hs)
    `CHK("dac_word", 16'h1555, dac_word)
    xfer(0, 0, BCAST_ADDR, 16'h0777, 1);
    `CHK("dac_word", 16'h0777, dac_word)
    xfer(1, 0, BCAST_ADDR, 16'h0777, 0);
    xfer(1, 1, 7'h0d, 16'h0777, 1);
    `CHK("upd_count", 4, upd_count)
    report_and_stop();
  end
endmodule : test_i2c_dac_register_slave
`default_nettype wire
